// ### lsc_chk.sv
// assertion checker for the lane control register bank
`timescale 1ns/1ps
`default_nettype none
module lsc_chk
#(
  parameter LANES = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic channel_power_down_n,
  input wire logic [7:0] pll_multiplier_x2,
  input wire logic pll_code_valid,
  input wire logic [3*LANES-1:0] output_swing_code,
  input wire logic [LANES-1:0] transmit_lane_enable,
  input wire logic [LANES-1:0] receive_lane_enable,
  input wire logic [4*LANES-1:0] equalizer_code
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // transfer taken at this edge
  logic take;
  logic take_wr;
  assign take = hsel & hready & htrans[1];
  assign take_wr = take & hwrite;
  // ----------------------------------------
  // bus timing
  // ----------------------------------------
  a_read_one_wait:
    assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_no_wait:
    assert property (take_wr |=> hreadyout)
    else $error("write stalled");
  a_resp_okay:
    assert property (hresp == 1'b0)
    else $error("error response");
  a_rdata_upper_zero:
    assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_rdata_held:
    assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  // ----------------------------------------
  // lane outputs
  // ----------------------------------------
  a_tx_pin_down:
    assert property (!channel_power_down_n [*3] |=> transmit_lane_enable == '0)
    else $error("tx lane not forced off");
  a_rx_needs_pin:
    assert property (|receive_lane_enable |-> $past(channel_power_down_n, 3))
    else $error("rx lane on while pin low");
  a_pll_valid_ratio:
    assert property (pll_code_valid == (pll_multiplier_x2 != 8'h00))
    else $error("multiplier and valid disagree");
  a_swing_by_write:
    assert property ($changed(output_swing_code) |-> $past(take_wr, 2))
    else $error("swing changed without write");
  a_eq_by_write:
    assert property ($changed(equalizer_code) |-> $past(take_wr, 2))
    else $error("equalizer changed without write");
  // main scenarios reached
  c_read: cover property (take && !hwrite);
  c_bad_code: cover property (!pll_code_valid);
  c_pin_low: cover property (!channel_power_down_n [*3]);
endmodule // lsc_chk

bind lsc_top lsc_chk #(.LANES(LANES)) u_chk
(
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .channel_power_down_n(channel_power_down_n),
  .pll_multiplier_x2(pll_multiplier_x2),
  .pll_code_valid(pll_code_valid),
  .output_swing_code(output_swing_code),
  .transmit_lane_enable(transmit_lane_enable),
  .receive_lane_enable(receive_lane_enable),
  .equalizer_code(equalizer_code)
);
`default_nettype wire

// ### lsc_defs.vh
// constants for the low-speed lane control register bank
`ifndef LSC_DEFS_VH
`define LSC_DEFS_VH

// register indices; byte address is four times the index
`define LSC_IDX_GLOBAL 8'h01
`define LSC_IDX_CTRL_A 8'h06
`define LSC_IDX_CTRL_B 8'h07
`define LSC_IDX_CTRL_C 8'h08
`define LSC_IDX_STATUS 8'h10

// reset values
`define LSC_RST_GLOBAL 16'h0000
`define LSC_RST_CTRL_A 16'h8115
`define LSC_RST_CTRL_B 16'hdc04
`define LSC_RST_CTRL_C 16'h000d

// global register
`define LSC_GLB_POWER_DOWN 15
// control a fields
`define LSC_A_BROADCAST 15
`define LSC_A_SEL_HI 14
`define LSC_A_SEL_LO 12
`define LSC_A_MPY_HI 3
`define LSC_A_MPY_LO 0
// control b fields
`define LSC_B_SWING_HI 14
`define LSC_B_SWING_LO 12
`define LSC_B_LOS_EN 11
`define LSC_B_TX_EN 10
`define LSC_B_TX_RATE_HI 9
`define LSC_B_TX_RATE_LO 8
`define LSC_B_DE_HI 7
`define LSC_B_DE_LO 4
`define LSC_B_RX_EN 2
`define LSC_B_RX_RATE_HI 1
`define LSC_B_RX_RATE_LO 0
// control c fields
`define LSC_C_RX_INV 15
`define LSC_C_TX_INV 14
`define LSC_C_EQ_HI 11
`define LSC_C_EQ_LO 8

// multiplier codes and their ratio times two (12.5x needs the half step)
`define LSC_MPY_4X 4'h0
`define LSC_MPY_5X 4'h1
`define LSC_MPY_6X 4'h2
`define LSC_MPY_8X 4'h4
`define LSC_MPY_10X 4'h5
`define LSC_MPY_12X 4'h6
`define LSC_MPY_12P5X 4'h7
`define LSC_MPY_15X 4'h8
`define LSC_MPY_20X 4'h9
`define LSC_MPY_25X 4'ha
`define LSC_MPY_50X 4'hd
`define LSC_MPY_65X 4'he
`define LSC_X2_4X 8'h08
`define LSC_X2_5X 8'h0a
`define LSC_X2_6X 8'h0c
`define LSC_X2_8X 8'h10
`define LSC_X2_10X 8'h14
`define LSC_X2_12X 8'h18
`define LSC_X2_12P5X 8'h19
`define LSC_X2_15X 8'h1e
`define LSC_X2_20X 8'h28
`define LSC_X2_25X 8'h32
`define LSC_X2_50X 8'h64
`define LSC_X2_65X 8'h82

// status register layout
`define LSC_ST_X2_HI 15
`define LSC_ST_X2_LO 8
`define LSC_ST_VALID 7
`define LSC_ST_FORCED 6

// ahb transfer type bit that marks an active transfer
`define LSC_HTRANS_ACTIVE 1

`endif

// ### lsc_lane_regs.v
// one lane's copy of the two lane-specific control registers
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.vh"

module lsc_lane_regs
(
  input wire hclk,
  input wire hresetn,
  input wire write_b,
  input wire write_c,
  input wire [15:0] wdata,
  output reg [15:0] ctrl_b,
  output reg [15:0] ctrl_c
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // every bit is kept, reserved ones too, so they read back as written
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_b <= `LSC_RST_CTRL_B;
      ctrl_c <= `LSC_RST_CTRL_C;
    end
    else
    begin
      if (write_b)
        ctrl_b <= wdata;
      if (write_c)
        ctrl_c <= wdata;
    end
  end

endmodule // lsc_lane_regs

`default_nettype wire

// ### lsc_top.v
// low-speed lane control register bank with ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.vh"

module lsc_top
#(
  parameter LANES = 4,
  parameter SEL_W = 3,
  parameter AW = 12
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [AW-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire channel_power_down_n,
  output reg [7:0] pll_multiplier_x2,
  output reg pll_code_valid,
  output wire [3*LANES-1:0] output_swing_code,
  output wire [LANES-1:0] signal_loss_detect_enable,
  output reg [LANES-1:0] transmit_lane_enable,
  output wire [2*LANES-1:0] transmit_lane_rate,
  output wire [4*LANES-1:0] deemphasis_code,
  output reg [LANES-1:0] receive_lane_enable,
  output wire [2*LANES-1:0] receive_lane_rate,
  output wire [LANES-1:0] receive_polarity_invert,
  output wire [LANES-1:0] transmit_polarity_invert,
  output wire [4*LANES-1:0] equalizer_code
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg [15:0] global_ctrl;
  reg [15:0] ctrl_a;
  reg pdn_meta;
  reg pdn_sync;
  reg wr_pending;
  reg [7:0] wr_index;
  reg rd_pending;
  reg [7:0] rd_index;
  reg [7:0] next_x2;
  reg next_valid;
  reg [15:0] next_rdata;
  wire [16*LANES-1:0] lane_b;
  wire [16*LANES-1:0] lane_c;
  wire [LANES-1:0] lane_wr;
  wire addr_phase;
  wire [7:0] addr_index;
  wire addr_aligned;
  wire wr_b;
  wire wr_c;
  wire broadcast;
  wire [SEL_W-1:0] lane_sel;
  wire sel_in_range;
  wire forced_down;
  wire [15:0] sel_b;
  wire [15:0] sel_c;
  wire [15:0] status_word;

  // ---------------------------------------------------------------
  // power-down pin synchroniser
  // ---------------------------------------------------------------
  // the pin is asynchronous to hclk; only the second stage is used
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pdn_meta <= 1'b0;
      pdn_sync <= 1'b0;
    end
    else
    begin
      pdn_meta <= channel_power_down_n;
      pdn_sync <= pdn_meta;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite address phase decode
  // ---------------------------------------------------------------
  assign addr_phase = hsel & hready & htrans[`LSC_HTRANS_ACTIVE];
  assign addr_index = haddr[9:2];
  assign addr_aligned = (haddr[1:0] == 2'b00) & (haddr[AW-1:10] == {(AW-10){1'b0}});

  // writes complete with no wait state; the index is held for the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending <= 1'b0;
      wr_index <= 8'h00;
    end
    else
    begin
      wr_pending <= addr_phase & hwrite & addr_aligned;
      if (addr_phase & hwrite)
        wr_index <= addr_index;
    end
  end

  // reads take one wait state, so a write in its data phase lands first
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_pending <= 1'b0;
      rd_index <= 8'h00;
      hreadyout <= 1'b1;
    end
    else
    begin
      rd_pending <= addr_phase & ~hwrite;
      hreadyout <= ~(addr_phase & ~hwrite);
      if (addr_phase & ~hwrite)
        rd_index <= addr_aligned ? addr_index : 8'hff;
    end
  end

  // the response is always okay; unmapped addresses read zero
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // ---------------------------------------------------------------
  // global and control a registers
  // ---------------------------------------------------------------
  // only the low half-word carries register data
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      global_ctrl <= `LSC_RST_GLOBAL;
      ctrl_a <= `LSC_RST_CTRL_A;
    end
    else if (wr_pending)
    begin
      if (wr_index == `LSC_IDX_GLOBAL)
        global_ctrl <= hwdata[15:0];
      if (wr_index == `LSC_IDX_CTRL_A)
        ctrl_a <= hwdata[15:0]; // reserved codes stored as written
    end
  end

  assign broadcast = ctrl_a[`LSC_A_BROADCAST];
  assign lane_sel = ctrl_a[`LSC_A_SEL_HI:`LSC_A_SEL_LO];
  // reserved selections 1xx address no lane unless broadcast is set
  assign sel_in_range = (lane_sel < LANES);

  // ---------------------------------------------------------------
  // lane write steering
  // ---------------------------------------------------------------
  assign wr_b = wr_pending & (wr_index == `LSC_IDX_CTRL_B);
  assign wr_c = wr_pending & (wr_index == `LSC_IDX_CTRL_C);

  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi = gi + 1)
    begin : g_lane
      // broadcast reaches every lane, otherwise only the chosen one
      assign lane_wr[gi] = broadcast | (lane_sel == gi);

      // each lane owns its own pair of registers
      lsc_lane_regs u_regs
      (
        .hclk(hclk),
        .hresetn(hresetn),
        .write_b(wr_b & lane_wr[gi]),
        .write_c(wr_c & lane_wr[gi]),
        .wdata(hwdata[15:0]),
        .ctrl_b(lane_b[16*gi +: 16]),
        .ctrl_c(lane_c[16*gi +: 16])
      );

      // field slices come straight from the lane flops
      assign output_swing_code[3*gi +: 3] =
        lane_b[16*gi+`LSC_B_SWING_LO +: 3];
      assign signal_loss_detect_enable[gi] =
        lane_b[16*gi+`LSC_B_LOS_EN];
      assign transmit_lane_rate[2*gi +: 2] =
        lane_b[16*gi+`LSC_B_TX_RATE_LO +: 2];
      assign deemphasis_code[4*gi +: 4] =
        lane_b[16*gi+`LSC_B_DE_LO +: 4];
      assign receive_lane_rate[2*gi +: 2] =
        lane_b[16*gi+`LSC_B_RX_RATE_LO +: 2];
      assign receive_polarity_invert[gi] =
        lane_c[16*gi+`LSC_C_RX_INV];
      assign transmit_polarity_invert[gi] =
        lane_c[16*gi+`LSC_C_TX_INV];
      assign equalizer_code[4*gi +: 4] =
        lane_c[16*gi+`LSC_C_EQ_LO +: 4];
    end
  endgenerate

  // ---------------------------------------------------------------
  // effective lane enables
  // ---------------------------------------------------------------
  // pin low or global power-down overrides the software enables
  assign forced_down = ~pdn_sync | global_ctrl[`LSC_GLB_POWER_DOWN];

  integer li;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      transmit_lane_enable <= {LANES{1'b0}};
      receive_lane_enable <= {LANES{1'b0}};
    end
    else
    begin
      for (li = 0; li < LANES; li = li + 1)
      begin
        transmit_lane_enable[li] <= lane_b[16*li+`LSC_B_TX_EN] & ~forced_down;
        receive_lane_enable[li] <= lane_b[16*li+`LSC_B_RX_EN] & ~forced_down;
      end
    end
  end

  // ---------------------------------------------------------------
  // pll multiplier decode
  // ---------------------------------------------------------------
  // reserved codes give zero ratio and drop the valid flag
  always @*
  begin
    next_valid = 1'b1;
    case (ctrl_a[`LSC_A_MPY_HI:`LSC_A_MPY_LO])
      `LSC_MPY_4X: next_x2 = `LSC_X2_4X;
      `LSC_MPY_5X: next_x2 = `LSC_X2_5X;
      `LSC_MPY_6X: next_x2 = `LSC_X2_6X;
      `LSC_MPY_8X: next_x2 = `LSC_X2_8X;
      `LSC_MPY_10X: next_x2 = `LSC_X2_10X;
      `LSC_MPY_12X: next_x2 = `LSC_X2_12X;
      `LSC_MPY_12P5X: next_x2 = `LSC_X2_12P5X;
      `LSC_MPY_15X: next_x2 = `LSC_X2_15X;
      `LSC_MPY_20X: next_x2 = `LSC_X2_20X;
      `LSC_MPY_25X: next_x2 = `LSC_X2_25X;
      `LSC_MPY_50X: next_x2 = `LSC_X2_50X;
      `LSC_MPY_65X: next_x2 = `LSC_X2_65X;
      default:
      begin
        next_x2 = 8'h00;
        next_valid = 1'b0;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pll_multiplier_x2 <= 8'h00;
      pll_code_valid <= 1'b0;
    end
    else
    begin
      pll_multiplier_x2 <= next_x2;
      pll_code_valid <= next_valid;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // reads follow the lane select; reserved selects read as zero
  assign sel_b = sel_in_range ? lane_b[16*lane_sel +: 16] : 16'h0000;
  assign sel_c = sel_in_range ? lane_c[16*lane_sel +: 16] : 16'h0000;
  assign status_word = {pll_multiplier_x2, pll_code_valid, forced_down, 6'b00_0000};

  always @*
  begin
    case (rd_index)
      `LSC_IDX_GLOBAL: next_rdata = global_ctrl;
      `LSC_IDX_CTRL_A: next_rdata = ctrl_a;
      `LSC_IDX_CTRL_B: next_rdata = sel_b;
      `LSC_IDX_CTRL_C: next_rdata = sel_c;
      `LSC_IDX_STATUS: next_rdata = status_word;
      default: next_rdata = 16'h0000;
    endcase
  end

  // data loaded in the wait cycle and held until the next read
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (rd_pending)
      hrdata <= {16'h0000, next_rdata};
  end

endmodule // lsc_top

`default_nettype wire

// ### tb_top.sv
// self-checking testbench for the lane control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic hclk;
  logic hresetn;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic pin_n;
  logic [7:0] x2;
  logic x2_ok;
  logic [11:0] swing;
  logic [3:0] los;
  logic [3:0] tx_en;
  logic [7:0] tx_rate;
  logic [15:0] de;
  logic [3:0] rx_en;
  logic [7:0] rx_rate;
  logic [3:0] rx_inv;
  logic [3:0] tx_inv;
  logic [15:0] eq;
  int n_mismatch;
  int compares;
  // ratio times two per multiplier code, zero where reserved
  // packed with code 15 at the top, so free simulators take it without array parameters
  localparam logic [127:0] RAT = {8'h00, 8'h82, 8'h64, 8'h00, 8'h00, 8'h32, 8'h28, 8'h1e,
    8'h19, 8'h18, 8'h14, 8'h10, 8'h00, 8'h0c, 8'h0a, 8'h08};

  lsc_top uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .channel_power_down_n(pin_n), .pll_multiplier_x2(x2), .pll_code_valid(x2_ok),
    .output_swing_code(swing), .signal_loss_detect_enable(los),
    .transmit_lane_enable(tx_en), .transmit_lane_rate(tx_rate),
    .deemphasis_code(de), .receive_lane_enable(rx_en), .receive_lane_rate(rx_rate),
    .receive_polarity_invert(rx_inv), .transmit_polarity_invert(tx_inv),
    .equalizer_code(eq)
  );

  // clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one single transfer; waits on hready, no fixed latency assumed
  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
    output logic [15:0] r);
    hwrite <= w;
    haddr <= a;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    r = hrdata[15:0];
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    logic [15:0] r;
    bus(1'b0, a, 16'h0000, r);
    chk(r, e);
  endtask

  task automatic summarize;
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(12'h01c, 16'hdc04);
    rd(12'h020, 16'h000d);
    chk(swing, {4{3'b101}});
    chk(los, 4'hf);
    chk({tx_en, rx_en}, 8'hff);
    chk({tx_rate, rx_rate, de}, 32'h0000_0000);
    chk({rx_inv, tx_inv, eq}, 24'h00_0000);
    chk(x2, 8'h14);
  endtask

  task automatic t_pll;
    for (int i = 0; i < 16; i++)
    begin
      wr(12'h018, 16'h8000 | 16'(i));
      repeat (2) @(posedge hclk);
      chk(x2, RAT[8*i +: 8]);
      chk(x2_ok, RAT[8*i +: 8] != 8'h00);
    end
    rd(12'h018, 16'h800f);
    wr(12'h018, 16'h8005);
  endtask

  // broadcast write, then one distinct value per lane
  task automatic t_lanes;
    wr(12'h01c, 16'h3295);
    repeat (2) @(posedge hclk);
    chk(swing, {4{3'b011}});
    chk(los, 4'h0);
    chk({tx_en, rx_en}, 8'h0f);
    chk({tx_rate, rx_rate, de}, {{4{2'b10}}, {4{2'b01}}, 16'h9999});
    for (int i = 0; i < 4; i++)
    begin
      wr(12'h018, 16'(i << 12));
      wr(12'h020, 16'h70a5 | 16'(i << 8) | (i == 3 ? 16'h8000 : 16'h0000));
    end
    // select 1xx reaches no lane and reads zero
    wr(12'h018, 16'h4000);
    wr(12'h020, 16'h0000);
    rd(12'h020, 16'h0000);
    chk({rx_inv, tx_inv, eq}, {4'h8, 4'hf, 16'h3210});
    wr(12'h018, 16'h2000);
    rd(12'h020, 16'h72a5);
    rd(12'h01c, 16'h3295);
    wr(12'h018, 16'h8005);
    wr(12'h01c, 16'hdc04);
  endtask

  task automatic t_power;
    pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({tx_en, rx_en}, 8'h00);
    pin_n <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({tx_en, rx_en}, 8'hff);
    wr(12'h004, 16'h8000);
    repeat (2) @(posedge hclk);
    chk({tx_en, rx_en}, 8'h00);
    wr(12'h004, 16'h0000);
    repeat (2) @(posedge hclk);
    chk({tx_en, rx_en}, 8'hff);
  endtask

  // unmapped and read-only places leave the lanes alone
  task automatic t_unmapped;
    wr(12'hc1c, 16'h0000);
    wr(12'h040, 16'h0000);
    rd(12'h01c, 16'hdc04);
    rd(12'h81c, 16'h0000);
    rd(12'h040, 16'h1480);
  endtask

  // main sequence
  initial
  begin
    hresetn = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    pin_n = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    // enables need three edges to come up after release
    repeat (4) @(posedge hclk);
    t_reset;
    t_pll;
    t_lanes;
    t_power;
    t_unmapped;
    summarize;
  end

  // watchdog, far beyond the 155 or so cycles the run needs
  initial
  begin
    #(40 * 4000);
    n_mismatch++;
    summarize;
  end
endmodule // tb_top
`default_nettype wire
